//--- rtl/bus_seq_pkg.sv
package bus_seq_pkg;
  // ----------------------------------------
  // instruction groups
  // ----------------------------------------
  typedef enum logic [3:0] {
    GRP_JUMP = 4'h0,
    GRP_ACC_READ = 4'h1,
    GRP_ACC_STORE = 4'h2,
    GRP_LOAD16 = 4'h3,
    GRP_STORE16 = 4'h4,
    GRP_RMW = 4'h5,
    GRP_ARITH16 = 4'h6,
    GRP_CALL = 4'h7
  } group_t;
  // ----------------------------------------
  // fixed values
  // ----------------------------------------
  localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
  localparam logic [1:0] MODE_ZERO = 2'h0;
  localparam logic [2:0] CYC_JUMP = 3'h3;
  localparam logic [2:0] CYC_ACC = 3'h4;
  localparam logic [2:0] CYC_WORD = 3'h5;
  localparam logic [2:0] CYC_LONG = 3'h6;
  localparam logic [15:0] RESET_ADDR = 16'hFFFF;
endpackage

//--- rtl/bus_drive_reg.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// registered bus drive stage
// ----------------------------------------
module bus_drive_reg (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [15:0] next_addr_in,
  input wire logic next_rw_in,
  input wire logic [7:0] next_data_in,
  input wire logic next_data_oe_n_in,
  output logic [15:0] addr_out,
  output logic rw_out,
  output logic [7:0] data_out,
  output logic data_oe_n_out
);
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_out <= 16'hFFFF;
      rw_out <= 1'b1;
      data_out <= 8'h00;
      data_oe_n_out <= 1'b1;
    end else begin
      addr_out <= next_addr_in;
      rw_out <= next_rw_in;
      data_out <= next_data_in;
      data_oe_n_out <= next_data_oe_n_in;
    end
  end
endmodule
`default_nettype wire

//--- rtl/bus_cycle_sequencer_ext_idx.sv
// Functional notes
// - absolute jump is 3 reads: opcode, target high, target low at successive addresses.
// - absolute accumulator ops take 4 cycles, the fourth reads or stores at the operand.
// - absolute 16-bit loads take 5 cycles, reading high at operand and low at operand+1.
// - absolute 16-bit stores take 5 cycles, writing high then low in cycles 4 and 5.
// - absolute read-modify-write takes 6 cycles: read, dummy FFFF read, write back.
// - absolute 16-bit compare/add/subtract take 6 cycles ending in a dummy FFFF read.
// - absolute call takes 6 cycles: target opcode read, then return low and high pushed.
// - indexed jump takes 3 cycles: opcode, offset, dummy FFFF read.
// - indexed accumulator ops take 4 cycles with a dummy FFFF then access at index+offset.
// - indexed 16-bit loads and stores take 5 cycles, high at X+off then low at X+off+1.
// - indexed read-modify-write takes 6 cycles with dummy reads in cycles 3 and 5.
// - indexed 16-bit compare/add/subtract take 6 cycles, ending in a dummy FFFF read.
// - indexed call takes 6 cycles: dummy, target opcode read, return low then high pushed.
// - internal read data stay off the external bus unless the mode is 0.
`timescale 1ns/1ns
`default_nettype none
module bus_cycle_sequencer_ext_idx
  import bus_seq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [3:0] group_in,
  input wire logic indexed_in,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] index_in,
  input wire logic [15:0] stack_in,
  input wire logic [15:0] store_data_in,
  input wire logic [7:0] new_operand_in,
  input wire logic [1:0] mode_in,
  input wire logic internal_in,
  input wire logic [7:0] internal_data_in,
  input wire logic [7:0] bus_data_in,
  output logic [15:0] addr_out,
  output logic rw_out,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  output logic busy_out,
  output logic [2:0] cycle_out,
  output logic done_out,
  output logic [15:0] operand_out
);
  // ----------------------------------------
  // sequence state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } state_t;
  state_t state;
  group_t grp;
  logic idx;
  logic [2:0] cyc;
  logic [2:0] last;
  logic [15:0] pc;
  logic [15:0] xr;
  logic [15:0] sp;
  logic [15:0] wdata;
  logic [15:0] ea;
  logic [15:0] ea_now;
  logic grab_low;
  logic [15:0] ret;
  logic [15:0] opnd;
  logic [7:0] rd_byte;
  logic [15:0] next_addr;
  logic next_rw;
  logic [7:0] next_data;
  logic [2:0] next_last;

  function automatic logic [2:0] cycles_of(input logic [3:0] g);
    case (g)
      GRP_JUMP: cycles_of = CYC_JUMP;
      GRP_ACC_READ, GRP_ACC_STORE: cycles_of = CYC_ACC;
      GRP_LOAD16, GRP_STORE16: cycles_of = CYC_WORD;
      default: cycles_of = CYC_LONG;
    endcase
  endfunction

  assign next_last = cycles_of(group_in);
  // on-chip reads come from the internal path, never the pins
  assign rd_byte = internal_in ? internal_data_in : bus_data_in;

  // ----------------------------------------
  // cycle counter
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      cyc <= 3'h1;
      last <= CYC_JUMP;
      grp <= GRP_JUMP;
      idx <= 1'b0;
      pc <= 16'h0000;
      xr <= 16'h0000;
      sp <= 16'h0000;
      wdata <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_in) begin
            state <= ST_RUN;
            cyc <= 3'h1;
            last <= next_last;
            grp <= group_t'(group_in);
            idx <= indexed_in;
            pc <= pc_in;
            xr <= index_in;
            sp <= stack_in;
            wdata <= store_data_in;
          end
        end
        ST_RUN: begin
          if (cyc == last) begin
            state <= ST_IDLE;
            cyc <= 3'h1;
          end else begin
            cyc <= cyc + 3'h1;
          end
          if (grp == GRP_RMW && cyc == 3'h5) begin
            wdata <= {8'h00, new_operand_in};
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // address capture from the fetched bytes
  // ----------------------------------------
  // a bus byte stands one count behind cyc, so the low address byte is used straight from rd_byte
  // while cycle 4 is planned; indexed sum is formed in the dummy
  assign ea_now = idx ? xr + ea : {ea[15:8], rd_byte};

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ea <= 16'h0000;
      opnd <= 16'h0000;
      grab_low <= 1'b0;
    end else begin
      // cycle 5 data arrive after the sequence may already be idle
      grab_low <= state == ST_RUN && cyc == 3'h5;
      if (grab_low) begin
        opnd[7:0] <= rd_byte;
      end
      if (state == ST_RUN) begin
        if (!idx && cyc == 3'h3) begin
          ea[15:8] <= rd_byte;
        end
        if (!idx && cyc == 3'h4) begin
          ea[7:0] <= rd_byte;
        end
        if (idx && cyc == 3'h3) begin
          ea <= {8'h00, rd_byte};
        end
        if (idx && cyc == 3'h4) begin
          ea <= ea_now;
        end
        if (cyc == 3'h5) begin
          opnd[15:8] <= rd_byte;
        end
      end
    end
  end

  // return address is the byte after the call instruction
  assign ret = idx ? pc + 16'h0002 : pc + 16'h0003;

  // ----------------------------------------
  // per-cycle bus plan
  // ----------------------------------------
  always_comb begin
    next_addr = DUMMY_ADDR;
    next_rw = 1'b1;
    next_data = 8'h00;
    if (state == ST_RUN) begin
      case (cyc)
        3'h1: next_addr = pc;
        3'h2: next_addr = pc + 16'h0001;
        3'h3: next_addr = idx ? DUMMY_ADDR : pc + 16'h0002;
        3'h4: begin
          next_addr = ea_now;
          if (grp == GRP_ACC_STORE) begin
            next_rw = 1'b0;
            next_data = wdata[7:0];
          end else if (grp == GRP_STORE16) begin
            next_rw = 1'b0;
            next_data = wdata[15:8];
          end else if (grp == GRP_CALL) begin
            next_addr = ea_now;
          end
        end
        3'h5: begin
          case (grp)
            GRP_LOAD16, GRP_ARITH16: next_addr = ea + 16'h0001;
            GRP_STORE16: begin
              next_addr = ea + 16'h0001;
              next_rw = 1'b0;
              next_data = wdata[7:0];
            end
            GRP_RMW: next_addr = DUMMY_ADDR;
            GRP_CALL: begin
              next_addr = sp;
              next_rw = 1'b0;
              next_data = ret[7:0];
            end
            default: next_addr = DUMMY_ADDR;
          endcase
        end
        3'h6: begin
          case (grp)
            GRP_RMW: begin
              next_addr = ea;
              next_rw = 1'b0;
              next_data = new_operand_in;
            end
            GRP_CALL: begin
              next_addr = sp - 16'h0001;
              next_rw = 1'b0;
              next_data = ret[15:8];
            end
            default: next_addr = DUMMY_ADDR;
          endcase
        end
        default: next_addr = DUMMY_ADDR;
      endcase
    end
  end

  // ----------------------------------------
  // registered pins and echo of internal reads
  // ----------------------------------------
  logic next_echo;
  assign next_echo = internal_in && next_rw && (mode_in == MODE_ZERO);

  bus_drive_reg u_drive (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .next_addr_in(next_addr),
    .next_rw_in(next_rw),
    .next_data_in(next_rw ? internal_data_in : next_data),
    .next_data_oe_n_in(next_rw ? !next_echo : 1'b0),
    .addr_out(addr_out),
    .rw_out(rw_out),
    .data_out(data_out),
    .data_oe_n_out(data_oe_n_out)
  );

  // ----------------------------------------
  // status
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      cycle_out <= 3'h0;
      done_out <= 1'b0;
      operand_out <= 16'h0000;
    end else begin
      busy_out <= state == ST_RUN;
      cycle_out <= state == ST_RUN ? cyc : 3'h0;
      done_out <= state == ST_RUN && cyc == last;
      operand_out <= opnd;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  jump_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state == ST_IDLE && start_in && group_in == GRP_JUMP |=> ##3 done_out)
    else $error("jump length wrong");
  acc_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state == ST_IDLE && start_in && group_in == GRP_ACC_STORE |=> ##4 (done_out && !rw_out))
    else $error("acc store fourth cycle wrong");
  word_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state == ST_IDLE && start_in && group_in == GRP_LOAD16 |=> ##5 (done_out && rw_out))
    else $error("word load length wrong");
  store_hi_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    busy_out && cycle_out == 3'h5 && grp == GRP_STORE16 |-> !rw_out && $past(!rw_out))
    else $error("store bytes not written");
  rmw_dummy_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    busy_out && cycle_out == 3'h5 && grp == GRP_RMW |-> addr_out == DUMMY_ADDR && rw_out)
    else $error("rmw dummy wrong");
  arith_tail_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    busy_out && cycle_out == 3'h6 && grp == GRP_ARITH16 |-> addr_out == DUMMY_ADDR && rw_out)
    else $error("arith tail wrong");
  call_push_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    busy_out && cycle_out == 3'h6 && grp == GRP_CALL |-> addr_out == $past(addr_out) - 16'h0001)
    else $error("call push order wrong");
  idx_dummy_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    busy_out && cycle_out == 3'h3 && idx |-> addr_out == DUMMY_ADDR && rw_out)
    else $error("indexed dummy wrong");
  write_drive_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !rw_out |-> !data_oe_n_out && busy_out)
    else $error("write without drive");
  rmw_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    busy_out && cycle_out == 3'h6 && grp == GRP_RMW |-> !rw_out && addr_out == $past(addr_out, 2))
    else $error("rmw write back wrong");
  call_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    busy_out && cycle_out == 3'h5 && grp == GRP_CALL |-> !rw_out && addr_out == sp)
    else $error("call low push wrong");
  echo_mode_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rw_out && !data_oe_n_out |-> $past(mode_in == MODE_ZERO && internal_in))
    else $error("internal read echoed");
endmodule
`default_nettype wire

//--- verification/bus_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// memory and peripheral far side
// ----------------------------------------
module bus_mem_model (
  input wire logic core_clk_in,
  input wire logic [15:0] addr_in,
  input wire logic rw_in,
  output logic [7:0] bus_data_out,
  output logic [7:0] internal_data_out
);
  logic [7:0] content;
  logic [7:0] last;
  assign content = addr_in[7:0] ^ addr_in[15:8] ^ 8'hA5;
  always_ff @(posedge core_clk_in) begin
    if (rw_in) begin
      last <= content;
    end
  end
  // released bus shows the inverse, so a stale byte never passes for read data
  assign bus_data_out = rw_in ? content : ~last;
  // on-chip space holds the same image, so fetched bytes match either source
  assign internal_data_out = content;
endmodule
`default_nettype wire

//--- verification/bus_cycle_sequencer_ext_idx_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bus_cycle_sequencer_ext_idx_tb import bus_seq_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic core_clk_in, rst_in, start_in, indexed_in, internal_in;
  logic [3:0] group_in;
  logic [15:0] pc_in, index_in, stack_in, store_data_in;
  logic [7:0] new_operand_in, internal_data_in, bus_data_in;
  logic [1:0] mode_in;
  logic [15:0] addr_out, operand_out;
  logic rw_out, data_oe_n_out, busy_out, done_out;
  logic [7:0] data_out;
  logic [2:0] cycle_out;
  int mismatches = 0;
  int samples_checked = 0;
  logic [15:0] lfsr = 16'h2947;
  logic [15:0] exp_addr[$];
  logic exp_rw[$];
  logic [7:0] exp_dat[$];
  bus_cycle_sequencer_ext_idx i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .start_in(start_in), .group_in(group_in), .indexed_in(indexed_in), .pc_in(pc_in),
    .index_in(index_in), .stack_in(stack_in), .store_data_in(store_data_in),
    .new_operand_in(new_operand_in), .mode_in(mode_in), .internal_in(internal_in),
    .internal_data_in(internal_data_in), .bus_data_in(bus_data_in), .addr_out(addr_out),
    .rw_out(rw_out), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
    .busy_out(busy_out), .cycle_out(cycle_out), .done_out(done_out),
    .operand_out(operand_out));
  bus_mem_model i_mem (.core_clk_in(core_clk_in), .addr_in(addr_out), .rw_in(rw_out),
    .bus_data_out(bus_data_in), .internal_data_out(internal_data_in));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic roll(output logic [15:0] v);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    v = lfsr;
  endtask
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  task automatic push(input logic [15:0] a, input logic w, input logic [7:0] d);
    exp_addr.push_back(a);
    exp_rw.push_back(w);
    exp_dat.push_back(d);
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // one instruction against the model
  // ----------------------------------------
  task automatic run_instr(input logic [3:0] g, input logic ix, input int abort);
    logic [15:0] pc, x, sp, sd, r, ea, ret;
    int n;
    exp_addr.delete();
    exp_rw.delete();
    exp_dat.delete();
    roll(pc);
    roll(x);
    roll(sp);
    roll(sd);
    roll(r);
    @(posedge core_clk_in);
    pc_in <= pc;
    index_in <= x;
    stack_in <= sp;
    store_data_in <= sd;
    new_operand_in <= r[7:0];
    mode_in <= r[9:8];
    internal_in <= r[10];
    group_in <= g;
    indexed_in <= ix;
    start_in <= 1'h1;
    push(pc, 1'h1, 8'h00);
    push(pc + 16'h1, 1'h1, 8'h00);
    if (ix) begin
      push(DUMMY_ADDR, 1'h1, 8'h00);
      ea = x + {8'h00, mem(pc + 16'h1)};
      ret = pc + 16'h2;
    end else begin
      push(pc + 16'h2, 1'h1, 8'h00);
      ea = {mem(pc + 16'h1), mem(pc + 16'h2)};
      ret = pc + 16'h3;
    end
    case (g)
      GRP_ACC_READ: push(ea, 1'h1, 8'h00);
      GRP_ACC_STORE: push(ea, 1'h0, sd[7:0]);
      GRP_LOAD16: begin push(ea, 1'h1, 8'h00); push(ea + 16'h1, 1'h1, 8'h00); end
      GRP_STORE16: begin push(ea, 1'h0, sd[15:8]); push(ea + 16'h1, 1'h0, sd[7:0]); end
      GRP_RMW: begin push(ea, 1'h1, 8'h00); push(DUMMY_ADDR, 1'h1, 8'h00); end
      GRP_ARITH16: begin push(ea, 1'h1, 8'h00); push(ea + 16'h1, 1'h1, 8'h00); end
      GRP_CALL: begin push(ea, 1'h1, 8'h00); push(sp, 1'h0, ret[7:0]); end
      default: ;
    endcase
    if (g == GRP_RMW) push(ea, 1'h0, r[7:0]);
    if (g == GRP_ARITH16) push(DUMMY_ADDR, 1'h1, 8'h00);
    if (g == GRP_CALL) push(sp - 16'h1, 1'h0, ret[15:8]);
    @(posedge core_clk_in);
    start_in <= 1'h0;
    n = exp_addr.size();
    for (int c = 0; c < n; c++) begin
      @(posedge core_clk_in);
      // a start while running must be ignored
      start_in <= (c == 1) ? r[11] : 1'h0;
      if (c == abort) begin
        rst_in <= 1'h1;
        #1;
        check("reset addr", addr_out, RESET_ADDR);
        check("reset busy", 16'(busy_out), 16'h0);
        @(posedge core_clk_in);
        rst_in <= 1'h0;
        return;
      end
      #1;
      check("addr", addr_out, exp_addr[c]);
      check("rw", 16'(rw_out), 16'(exp_rw[c]));
      if (!exp_rw[c]) begin
        check("data", 16'(data_out), 16'(exp_dat[c]));
        check("oe_n", 16'(data_oe_n_out), 16'h0);
      end else begin
        check("oe_n", 16'(data_oe_n_out), 16'(!(r[10] && r[9:8] == MODE_ZERO)));
      end
      check("cycle", 16'(cycle_out), 16'(c + 1));
      check("busy", 16'(busy_out), 16'h1);
      check("done", 16'(done_out), 16'(c == n - 1));
    end
    @(posedge core_clk_in);
    #1;
    check("idle", 16'(busy_out), 16'h0);
    if (g == GRP_LOAD16 || g == GRP_ARITH16) begin
      @(posedge core_clk_in);
      #1;
      check("operand", operand_out, {mem(ea), mem(ea + 16'h1)});
    end
  endtask
  // ----------------------------------------
  // run
  // ----------------------------------------
  always #5 core_clk_in = ~core_clk_in;
  initial begin
    #50000;
    mismatches++;
    complete_run();
  end
  initial begin
    core_clk_in = 1'h0;
    rst_in = 1'h1;
    start_in = 1'h0;
    group_in = 4'h0;
    indexed_in = 1'h0;
    internal_in = 1'h0;
    pc_in = 16'h0;
    index_in = 16'h0;
    stack_in = 16'h0;
    store_data_in = 16'h0;
    new_operand_in = 8'h00;
    mode_in = 2'h0;
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'h0;
    #1;
    check("reset addr", addr_out, RESET_ADDR);
    check("reset rw", 16'(rw_out), 16'h1);
    check("reset oe_n", 16'(data_oe_n_out), 16'h1);
    for (int i = 0; i < 48; i++) begin
      run_instr(4'(i % 8), i[3], (i == 29) ? 2 : 99);
    end
    complete_run();
  end
endmodule
`default_nettype wire
